// ### rtl/bsfb_defines.svh
// Offsets, field positions and reset values of the function box
`ifndef BSFB_DEFINES_SVH
`define BSFB_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define BSFB_OFS_FIRST_OPERAND    8'h00
`define BSFB_OFS_SECOND_OPERAND   8'h04
`define BSFB_OFS_CONTROL_BYTE     8'h08
`define BSFB_OFS_CARRY            8'h0c
`define BSFB_OFS_INTERRUPT        8'h10
`define BSFB_OFS_SUM              8'h20
`define BSFB_OFS_DIFFERENCE       8'h24
`define BSFB_OFS_AND              8'h28
`define BSFB_OFS_XOR              8'h2c
`define BSFB_OFS_OR               8'h30
`define BSFB_OFS_COMPLEMENT_FIRST 8'h34
`define BSFB_OFS_COMPLEMENT_SECOND 8'h38
`define BSFB_OFS_MASKED_FIRST     8'h3c
`define BSFB_OFS_MASKED_SECOND    8'h40
`define BSFB_OFS_BINARY_COND      8'h44
`define BSFB_OFS_RELATION_COND    8'h48
`define BSFB_OFS_OPERAND_STATE    8'h4c

// ==========================================================
// Control byte fields
`define BSFB_CTL_CARRY_BIT  7
`define BSFB_CTL_UNIT_HI    6
`define BSFB_CTL_UNIT_LO    5
`define BSFB_CTL_LEN_HI     4
`define BSFB_CTL_LEN_LO     0

// Interrupt register: first nibble low, second nibble high
`define BSFB_INT_FIRST_LO   0
`define BSFB_INT_SECOND_LO  4
`define BSFB_IRQ_CONSOLE    0
`define BSFB_IRQ_IO         1
`define BSFB_IRQ_TIMER      2
`define BSFB_IRQ_CON_STATE  3
`define BSFB_IRQ_PARITY     3

// ==========================================================
// Limits and reset values
`define BSFB_MAX_LEN        5'd24
`define BSFB_DEC_NINE       4'h9
`define BSFB_RST_OPERAND    24'h000000
`define BSFB_RST_LEN        5'd24
`define BSFB_RST_NIBBLE     4'h0

`endif

// ### rtl/bsfb_pkg.sv
// Types shared by the function box and its bench
package bsfb_pkg;

    // ======================================================
    // Unit type select
    typedef enum logic [1:0] {
        BSFB_UNIT_BIN  = 2'b00,
        BSFB_UNIT_DEC  = 2'b01,
        BSFB_UNIT_UND2 = 2'b10,
        BSFB_UNIT_UND3 = 2'b11
    } bsfb_unit_e;

    // Combined control byte
    typedef struct packed {
        logic carry_flag;
        bsfb_unit_e unit_type;
        logic [4:0] operand_length;
    } bsfb_ctrl_s;

    // Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } bsfb_wb_req_s;

    // Interrupt sources, one-cycle set pulses
    typedef struct packed {
        logic parity_error;
        logic timer_tick;
        logic io_request;
        logic console_int;
    } bsfb_irq_ev_s;

endpackage

// ### rtl/bsfb_top.sv
// 24-bit decimal/binary function box with Wishbone register access
// Contract
// - Unit select 00 means binary bits, 01 means decimal digits, others undefined.
// - All results follow inputs combinationally, no pipeline stage.
// - Sum is first plus second plus carry, zero above operand length.
// - Binary unit gives a plain binary sum.
// - Decimal unit adds six digits, carrying when a digit sum exceeds nine.
// - Difference adds first to complements of second and carry, length limited.
// - Borrow out flags a negative difference over all 24 bits.
// - Binary negative difference appears in two's complement.
// - Decimal difference borrows digit to digit, ten's complement when negative.
// - AND, OR, XOR outputs, zero above operand length.
// - Complement of each operand, zero above operand length.
// - Masked operands pass only the low operand-length bits.
// - Binary nibble: second last-unit, carry flag, borrow out, carry out.
// - Second last-unit is low unit equal one, or nine in decimal.
// - Carry depends on operands, carry flag and length; borrow on whole operands and carry flag only.
// - Carry flag written by carry command or control byte bit 7.
// - Relation nibble: top bit, equal, less, greater; unsigned 24 bits.
// - Top bit flag is first operand bit at the length's top position.
// - Interrupt pending ORs timer, I/O, console and parity bits.
// - State nibble: first last-unit, pending, second nonzero, first nonzero.
// - First last-unit is low unit equal one, or nine in decimal.
// - Parity error sets second interrupt nibble bit 3.
`timescale 1ns/1ps
`default_nettype none
`include "bsfb_defines.svh"

module bsfb_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire bsfb_pkg::bsfb_wb_req_s wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt sources
    input wire bsfb_pkg::bsfb_irq_ev_s irq_ev_i,
    // Interrupt pending level
    output logic int_pending_o
);
    import bsfb_pkg::*;

    // ======================================================
    // Functions
    function automatic logic [4:0] eff_len(input logic [4:0] len);
        // Reserved lengths behave as full width
        eff_len = (len > `BSFB_MAX_LEN) ? `BSFB_MAX_LEN : len;
    endfunction

    function automatic logic [23:0] len_mask(input logic [4:0] len);
        logic [24:0] m;
        m = (25'h1 << eff_len(len)) - 25'h1;
        len_mask = m[23:0];
    endfunction

    function automatic logic [24:0] dec_add(input logic [23:0] a,
                                            input logic [23:0] b,
                                            input logic c);
        logic [4:0] d;
        logic cy;
        logic [23:0] r;
        cy = c;
        r = 24'h000000;
        for (int i = 0; i < 6; i++)
        begin
            d = {1'b0, a[4*i +: 4]} + {1'b0, b[4*i +: 4]} + {4'h0, cy};
            if (d > 5'd9)
            begin
                d = d + 5'd6;
                cy = 1'b1;
            end
            else
            begin
                cy = 1'b0;
            end
            r[4*i +: 4] = d[3:0];
        end
        dec_add = {cy, r};
    endfunction

    function automatic logic [23:0] dec_sub(input logic [23:0] a,
                                            input logic [23:0] b,
                                            input logic c);
        logic [4:0] d;
        logic br;
        logic [23:0] r;
        br = c;
        r = 24'h000000;
        for (int i = 0; i < 6; i++)
        begin
            d = {1'b0, a[4*i +: 4]} - {1'b0, b[4*i +: 4]} - {4'h0, br};
            if (d[4])
            begin
                d = d + 5'd10;
                br = 1'b1;
            end
            else
            begin
                br = 1'b0;
            end
            r[4*i +: 4] = d[3:0];
        end
        dec_sub = r;
    endfunction

    function automatic logic last_unit(input logic [23:0] v, input bsfb_unit_e u);
        case (u)
            BSFB_UNIT_BIN: last_unit = v[0];
            BSFB_UNIT_DEC: last_unit = (v[3:0] == `BSFB_DEC_NINE);
            default: last_unit = 1'b0;
        endcase
    endfunction

    // ======================================================
    // Software-visible state
    logic [23:0] first_operand;
    logic [23:0] second_operand;
    bsfb_ctrl_s ctrl;
    logic [3:0] first_interrupt_nibble;
    logic [3:0] second_interrupt_nibble;

    logic bus_req;
    logic bus_wr;
    logic [7:0] adr;
    logic [31:0] wdat;
    logic [3:0] sel;
    assign bus_req = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
    assign bus_wr = bus_req & wb_req_i.we;
    assign adr = wb_req_i.adr;
    assign wdat = wb_req_i.dat;
    assign sel = wb_req_i.sel;

    // ======================================================
    // Function box
    logic [23:0] mask;
    logic [23:0] mfirst;
    logic [23:0] msecond;
    logic [24:0] raw_sum;
    logic [23:0] raw_difference;
    logic [23:0] sum_result;
    logic [23:0] difference_result;
    logic carry_out;
    logic borrow_out;
    logic first_top_bit_flag;
    logic first_last_unit_flag;
    logic second_last_unit_flag;
    logic int_pending;
    logic [3:0] binary_condition_nibble;
    logic [3:0] relation_condition_nibble;
    logic [3:0] operand_state_nibble;
    logic [4:0] elen;

    assign elen = eff_len(ctrl.operand_length);
    assign mask = len_mask(ctrl.operand_length);
    assign mfirst = first_operand & mask;
    assign msecond = second_operand & mask;

    always_comb
    begin
        // Undefined unit types fall back to binary for determinism
        if (ctrl.unit_type == BSFB_UNIT_DEC)
        begin
            raw_sum = dec_add(mfirst, msecond, ctrl.carry_flag);
            raw_difference = dec_sub(mfirst, msecond, ctrl.carry_flag);
        end
        else
        begin
            raw_sum = {1'b0, mfirst} + {1'b0, msecond}
                      + {24'h000000, ctrl.carry_flag};
            raw_difference = mfirst + ~msecond + {23'h0, ~ctrl.carry_flag};
        end
    end

    assign sum_result = raw_sum[23:0] & mask;
    assign difference_result = raw_difference & mask;
    // Carry taken at the length boundary; lengths off the unit grid give junk
    assign carry_out = raw_sum[elen];
    // Borrow ignores the length and looks at the whole operands
    assign borrow_out = ({1'b0, first_operand} <
                         ({1'b0, second_operand} + {24'h000000, ctrl.carry_flag}));
    assign first_top_bit_flag = (elen != 5'd0) &&
                                first_operand[5'(elen - 5'd1)];
    assign first_last_unit_flag = last_unit(first_operand, ctrl.unit_type);
    assign second_last_unit_flag = last_unit(second_operand, ctrl.unit_type);
    assign int_pending = first_interrupt_nibble[`BSFB_IRQ_TIMER] |
                         first_interrupt_nibble[`BSFB_IRQ_IO] |
                         first_interrupt_nibble[`BSFB_IRQ_CONSOLE] |
                         second_interrupt_nibble[`BSFB_IRQ_PARITY];
    assign binary_condition_nibble = {second_last_unit_flag, ctrl.carry_flag,
                                      borrow_out, carry_out};
    assign relation_condition_nibble = {first_top_bit_flag,
                                        first_operand == second_operand,
                                        first_operand < second_operand,
                                        first_operand > second_operand};
    assign operand_state_nibble = {first_last_unit_flag, int_pending,
                                   second_operand != 24'h000000,
                                   first_operand != 24'h000000};

    // ======================================================
    // Operand registers, byte lanes honoured
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            first_operand <= `BSFB_RST_OPERAND;
            second_operand <= `BSFB_RST_OPERAND;
        end
        else if (bus_wr)
        begin
            for (int b = 0; b < 3; b++)
            begin
                if (sel[b] && adr == `BSFB_OFS_FIRST_OPERAND)
                    first_operand[8*b +: 8] <= wdat[8*b +: 8];
                if (sel[b] && adr == `BSFB_OFS_SECOND_OPERAND)
                    second_operand[8*b +: 8] <= wdat[8*b +: 8];
            end
        end
    end

    // ======================================================
    // Control byte and carry command
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl.carry_flag <= 1'b0;
            ctrl.unit_type <= BSFB_UNIT_BIN;
            ctrl.operand_length <= `BSFB_RST_LEN;
        end
        else if (bus_wr && sel[0])
        begin
            if (adr == `BSFB_OFS_CONTROL_BYTE)
            begin
                ctrl.carry_flag <= wdat[`BSFB_CTL_CARRY_BIT];
                ctrl.unit_type <= bsfb_unit_e'(wdat[`BSFB_CTL_UNIT_HI:`BSFB_CTL_UNIT_LO]);
                ctrl.operand_length <= wdat[`BSFB_CTL_LEN_HI:`BSFB_CTL_LEN_LO];
            end
            else if (adr == `BSFB_OFS_CARRY)
            begin
                ctrl.carry_flag <= wdat[0];
            end
        end
    end

    // ======================================================
    // Interrupt nibbles: hardware set wins over a software write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            first_interrupt_nibble <= `BSFB_RST_NIBBLE;
            second_interrupt_nibble <= `BSFB_RST_NIBBLE;
        end
        else
        begin
            if (bus_wr && sel[0] && adr == `BSFB_OFS_INTERRUPT)
            begin
                first_interrupt_nibble <= wdat[`BSFB_INT_FIRST_LO +: 4] |
                    {1'b0, irq_ev_i.timer_tick, irq_ev_i.io_request,
                     irq_ev_i.console_int};
                second_interrupt_nibble <=
                    {wdat[`BSFB_INT_SECOND_LO + 3] | irq_ev_i.parity_error,
                     3'b000};
            end
            else
            begin
                first_interrupt_nibble[`BSFB_IRQ_TIMER] <=
                    first_interrupt_nibble[`BSFB_IRQ_TIMER] | irq_ev_i.timer_tick;
                first_interrupt_nibble[`BSFB_IRQ_IO] <=
                    first_interrupt_nibble[`BSFB_IRQ_IO] | irq_ev_i.io_request;
                first_interrupt_nibble[`BSFB_IRQ_CONSOLE] <=
                    first_interrupt_nibble[`BSFB_IRQ_CONSOLE] | irq_ev_i.console_int;
                second_interrupt_nibble[`BSFB_IRQ_PARITY] <=
                    second_interrupt_nibble[`BSFB_IRQ_PARITY] |
                    irq_ev_i.parity_error;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            int_pending_o <= 1'b0;
        else
            int_pending_o <= int_pending;
    end

    // ======================================================
    // Wishbone answer, one wait state, unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_req_i.we)
            begin
                case (adr)
                    `BSFB_OFS_FIRST_OPERAND: wb_dat_o <= {8'h00, first_operand};
                    `BSFB_OFS_SECOND_OPERAND: wb_dat_o <= {8'h00, second_operand};
                    `BSFB_OFS_CONTROL_BYTE: wb_dat_o <= {24'h000000, ctrl};
                    `BSFB_OFS_CARRY: wb_dat_o <= {31'h0, ctrl.carry_flag};
                    `BSFB_OFS_INTERRUPT: wb_dat_o <= {24'h000000,
                        second_interrupt_nibble, first_interrupt_nibble};
                    `BSFB_OFS_SUM: wb_dat_o <= {8'h00, sum_result};
                    `BSFB_OFS_DIFFERENCE: wb_dat_o <= {8'h00, difference_result};
                    `BSFB_OFS_AND: wb_dat_o <= {8'h00, mfirst & msecond};
                    `BSFB_OFS_XOR: wb_dat_o <= {8'h00, mfirst ^ msecond};
                    `BSFB_OFS_OR: wb_dat_o <= {8'h00, mfirst | msecond};
                    `BSFB_OFS_COMPLEMENT_FIRST: wb_dat_o <= {8'h00, ~first_operand & mask};
                    `BSFB_OFS_COMPLEMENT_SECOND: wb_dat_o <= {8'h00, ~second_operand & mask};
                    `BSFB_OFS_MASKED_FIRST: wb_dat_o <= {8'h00, mfirst};
                    `BSFB_OFS_MASKED_SECOND: wb_dat_o <= {8'h00, msecond};
                    `BSFB_OFS_BINARY_COND: wb_dat_o <= {28'h0000000, binary_condition_nibble};
                    `BSFB_OFS_RELATION_COND: wb_dat_o <= {28'h0000000, relation_condition_nibble};
                    `BSFB_OFS_OPERAND_STATE: wb_dat_o <= {28'h0000000, operand_state_nibble};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // ======================================================
    // Checks
    property p_bin_sum;
        @(posedge clk_i) disable iff (rst_i)
        (ctrl.unit_type == BSFB_UNIT_BIN && ctrl.operand_length == 5'd24) |->
        sum_result == 24'(first_operand + second_operand + 24'(ctrl.carry_flag));
    endproperty
    a_bin_sum: assert property (p_bin_sum) else $error("binary sum wrong");

    property p_limit;
        @(posedge clk_i) disable iff (rst_i)
        ((sum_result | difference_result) & ~mask) == 24'h000000;
    endproperty
    a_limit: assert property (p_limit) else $error("bits above length set");

    property p_zero_len;
        @(posedge clk_i) disable iff (rst_i)
        ctrl.operand_length == 5'd0 |-> (sum_result == 24'h000000 && mfirst == 24'h000000);
    endproperty
    a_zero_len: assert property (p_zero_len) else $error("zero length not zero");

    property p_borrow;
        @(posedge clk_i) disable iff (rst_i)
        (first_operand > second_operand) |-> !borrow_out;
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow wrong");

    property p_bin_difference_result;
        @(posedge clk_i) disable iff (rst_i)
        (ctrl.unit_type == BSFB_UNIT_BIN && ctrl.operand_length == 5'd24) |->
        difference_result == 24'(first_operand - second_operand - 24'(ctrl.carry_flag));
    endproperty
    a_bin_difference_result: assert property (p_bin_difference_result) else $error("binary difference wrong");

    property p_dec_lsu;
        @(posedge clk_i) disable iff (rst_i)
        (ctrl.unit_type == BSFB_UNIT_DEC && second_operand[3:0] == 4'h9) |->
        binary_condition_nibble[3];
    endproperty
    a_dec_lsu: assert property (p_dec_lsu) else $error("second last unit wrong");

    property p_relation;
        @(posedge clk_i) disable iff (rst_i)
        $onehot(relation_condition_nibble[2:0]);
    endproperty
    a_relation: assert property (p_relation) else $error("relation not one-hot");

    property p_parity;
        @(posedge clk_i) disable iff (rst_i)
        irq_ev_i.parity_error |=> second_interrupt_nibble[3] ##1 int_pending_o;
    endproperty
    a_parity: assert property (p_parity) else $error("parity event lost");

    property p_carry_cmd;
        @(posedge clk_i) disable iff (rst_i)
        (bus_wr && sel[0] && adr == `BSFB_OFS_CARRY) |=> ctrl.carry_flag == $past(wdat[0]);
    endproperty
    a_carry_cmd: assert property (p_carry_cmd) else $error("carry command ignored");

    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

endmodule
`default_nettype wire

// ### testbench/bsfb_irq_src.sv
// Interrupt source model that raises the function box's event lines
`timescale 1ns/1ps
`default_nettype none

module bsfb_irq_src (
    // Clock
    input wire logic clk_i,
    // Event lines to the function box
    output var bsfb_pkg::bsfb_irq_ev_s irq_ev_o
);
    import bsfb_pkg::*;

    // ==========================================================
    // Event pulses
    initial irq_ev_o = '0;

    // One-cycle pulse on one source; memory parity is index 3
    task automatic pulse(input int idx);
        @(posedge clk_i);
        irq_ev_o[idx] <= 1'b1;
        @(posedge clk_i);
        irq_ev_o <= '0;
    endtask
endmodule

`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the function box over its register bus
`timescale 1ns/1ps
`default_nettype none
`include "bsfb_defines.svh"

module testbench;
    import bsfb_pkg::*;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    bsfb_wb_req_s wb_req = '0;
    logic [31:0] wb_dat;
    logic wb_ack;
    bsfb_irq_ev_s irq_ev;
    logic int_pending;
    int err_count = 0;
    int checked = 0;
    logic [31:0] q;
    logic [31:0] irq_exp [4] = '{32'h01, 32'h02, 32'h04, 32'h80};

    // ==========================================================
    // Clock, design and partner
    always #2.5 clk_i = ~clk_i;

    bsfb_top dut_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_req_i(wb_req),
        .wb_dat_o(wb_dat),
        .wb_ack_o(wb_ack),
        .irq_ev_i(irq_ev),
        .int_pending_o(int_pending)
    );

    bsfb_irq_src src_u (
        .clk_i(clk_i),
        .irq_ev_o(irq_ev)
    );

    // ==========================================================
    // Bus tasks and comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic cycle; waits for ack without assuming its latency
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50)
            chk(32'hdead, 32'h0);
        q = wb_dat;
        wb_req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // Loads operands and control byte in one go
    task automatic setup(input logic [23:0] x, input logic [23:0] y, input logic [7:0] c);
        wr(`BSFB_OFS_FIRST_OPERAND, {8'h00, x});
        wr(`BSFB_OFS_SECOND_OPERAND, {8'h00, y});
        wr(`BSFB_OFS_CONTROL_BYTE, {24'h0, c});
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // Watchdog, well above the few hundred cycles the tests need
    initial
    begin
        #(5 * 20000);
        err_count++;
        results();
    end

    // ==========================================================
    // Tests
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`BSFB_OFS_CONTROL_BYTE, 32'h18);
        rd(`BSFB_OFS_INTERRUPT, 32'h0);
        chk({31'h0, int_pending}, 32'h0);
        rd(8'h50, 32'h0);
        wr(8'h54, 32'hffffffff);
        // Binary, full length
        setup(24'h123456, 24'h000fff, 8'h18);
        rd(`BSFB_OFS_SUM, 32'h124455);
        rd(`BSFB_OFS_BINARY_COND, 32'h8);
        // Binary, length 8: carry out at bit 8, top bit from bit 7
        setup(24'habcdef, 24'h000011, 8'h08);
        rd(`BSFB_OFS_SUM, 32'h0);
        rd(`BSFB_OFS_DIFFERENCE, 32'hde);
        rd(`BSFB_OFS_BINARY_COND, 32'h9);
        rd(`BSFB_OFS_RELATION_COND, 32'h9);
        // Decimal carry ripples through five digits
        setup(24'h199999, 24'h000001, 8'h38);
        rd(`BSFB_OFS_SUM, 32'h200000);
        rd(`BSFB_OFS_DIFFERENCE, 32'h199998);
        rd(`BSFB_OFS_BINARY_COND, 32'h0);
        // Decimal negative result in ten's complement
        setup(24'h000010, 24'h000025, 8'h38);
        rd(`BSFB_OFS_SUM, 32'h35);
        rd(`BSFB_OFS_DIFFERENCE, 32'h999985);
        rd(`BSFB_OFS_BINARY_COND, 32'h2);
        // Binary negative with carry set by the carry command
        setup(24'h000005, 24'h000007, 8'h18);
        wr(`BSFB_OFS_CARRY, 32'h1);
        rd(`BSFB_OFS_CONTROL_BYTE, 32'h98);
        rd(`BSFB_OFS_SUM, 32'hd);
        rd(`BSFB_OFS_DIFFERENCE, 32'hfffffd);
        rd(`BSFB_OFS_BINARY_COND, 32'he);
        wr(`BSFB_OFS_CARRY, 32'h0);
        // Logic, complement and mask at length 12
        setup(24'hf0f0f0, 24'h0ff0ff, 8'h0c);
        rd(`BSFB_OFS_AND, 32'h0f0);
        rd(`BSFB_OFS_OR, 32'h0ff);
        rd(`BSFB_OFS_XOR, 32'h00f);
        rd(`BSFB_OFS_COMPLEMENT_FIRST, 32'hf0f);
        rd(`BSFB_OFS_COMPLEMENT_SECOND, 32'hf00);
        rd(`BSFB_OFS_MASKED_FIRST, 32'h0f0);
        rd(`BSFB_OFS_MASKED_SECOND, 32'h0ff);
        rd(`BSFB_OFS_RELATION_COND, 32'h1);
        // Zero length clears limited results only
        wr(`BSFB_OFS_CONTROL_BYTE, 32'h00);
        rd(`BSFB_OFS_SUM, 32'h0);
        rd(`BSFB_OFS_AND, 32'h0);
        rd(`BSFB_OFS_MASKED_FIRST, 32'h0);
        rd(`BSFB_OFS_BINARY_COND, 32'h8);
        // Each interrupt source, pending flag and state nibble
        setup(24'h000009, 24'h000000, 8'h38);
        for (int i = 0; i < 4; i++)
        begin
            src_u.pulse(i);
            repeat (3) @(posedge clk_i);
            chk({31'h0, int_pending}, 32'h1);
            rd(`BSFB_OFS_INTERRUPT, irq_exp[i]);
            rd(`BSFB_OFS_OPERAND_STATE, 32'hd);
            wr(`BSFB_OFS_INTERRUPT, 32'h0);
        end
        repeat (3) @(posedge clk_i);
        chk({31'h0, int_pending}, 32'h0);
        rd(`BSFB_OFS_OPERAND_STATE, 32'h9);
        // Undefined unit runs as binary with last-unit flags low; carry from bit 7
        setup(24'h000009, 24'h000001, 8'hd8);
        rd(`BSFB_OFS_CONTROL_BYTE, 32'hd8);
        rd(`BSFB_OFS_SUM, 32'hb);
        rd(`BSFB_OFS_BINARY_COND, 32'h4);
        rd(`BSFB_OFS_OPERAND_STATE, 32'h3);
        results();
    end
endmodule

`default_nettype wire
